// ==== verilog/dcsm_cfg.svh ====
// Address map, field positions and code values of the converter configuration bank.
// Assumes a 32-bit APB slave in which every register index maps to byte address index*4.
`ifndef DCSM_CFG_SVH
`define DCSM_CFG_SVH
// ==========================================================================
// Register indices (byte address is four times the index)
`define DCSM_PAGE_A 16'h5000
`define DCSM_PAGE_B 16'h5800
`define DCSM_IDX_EN 16'h0000
`define DCSM_IDX_RATIO 16'h0001
`define DCSM_IDX_BAND 16'h0002
`define DCSM_IDX_SYNC 16'h003E
`define DCSM_IDX_STATUS 16'h0040
// ==========================================================================
// Field positions
`define DCSM_BIT_CLKDIV 6
`define DCSM_BIT_OSC 5
`define DCSM_BIT_EN 0
`define DCSM_BIT_BAND 0
`define DCSM_RATIO_MSB 3
`define DCSM_ST_LEVEL 0
`define DCSM_ST_BAD_A 1
`define DCSM_ST_BAD_B 2
// ==========================================================================
// Decimation ratio codes and the divisors they select
`define DCSM_DEC4 4'h0
`define DCSM_DEC6 4'h1
`define DCSM_DEC8 4'h2
`define DCSM_DEC9 4'h3
`define DCSM_DEC10 4'h4
`define DCSM_DEC12 4'h5
`define DCSM_DEC18A 4'h7
`define DCSM_DEC18B 4'h8
`define DCSM_DEC20 4'h9
`define DCSM_DEC32 4'hC
`define DCSM_DIV4 6'h04
`define DCSM_DIV6 6'h06
`define DCSM_DIV8 6'h08
`define DCSM_DIV9 6'h09
`define DCSM_DIV10 6'h0A
`define DCSM_DIV12 6'h0C
`define DCSM_DIV18 6'h12
`define DCSM_DIV20 6'h14
`define DCSM_DIV32 6'h20
`define DCSM_DIV_NONE 6'h00
`endif

// ==== verilog/dcsm_pkg.sv ====
// Types shared by the converter configuration bank.
// Assumes dcsm_cfg.svh is on the include path.
package dcsm_pkg;
  // ========================================================================
  // Complete state of the bank, registered as one word.
  typedef struct packed {
    logic sync0;
    logic sync1;
    logic sync2;
    logic mask_clkdiv;
    logic mask_osc;
    logic [1:0] downconverter_enable;
    logic [1:0][3:0] ratio;
    logic [1:0][5:0] div;
    logic [1:0] ratio_bad;
    logic [1:0] dual_band;
    logic clkdiv_rst;
    logic osc_rst;
    logic local_multiframe_counter_rst;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dcsm_state_t;
endpackage : dcsm_pkg

// ==== verilog/dcsm_top.sv ====
// Configuration bank for the downconverter and the SYSREF masks of a two-channel converter.
// Assumes an APB master on clk_sys and a SYSREF pin that is asynchronous to clk_sys.
// Assumes the host keeps reserved bits at zero and programs only listed ratio codes.
// Assumes sysref stays low for at least two cycles between rising edges.
//
// Functional notes
// - Unmasked SYSREF rise resets input clock divider.
// - Unmasked SYSREF rise resets oscillator and multiframe counter.
// - Per-channel decimation pages at 5000h and 5800h.
// - Enable bit chooses decimation filter or bypass.
// - Ratio codes 0-2 give divide 4, 6, 8.
// - Ratio codes 3-5 give divide 9, 10, 12.
// - Ratio codes 9 and C give 20, 32.
// - Codes 7 and 8 both decode as 18.
// - Band bit selects single or dual band.
`timescale 1ns/100ps
`include "dcsm_cfg.svh"

module dcsm_top
  import dcsm_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // SYSREF pin and the resets it triggers.
  input wire logic sysref,
  output logic clkdiv_reset,
  output logic osc_phase_reset,
  output logic local_multiframe_counter_reset,
  // Channel A datapath controls.
  output logic downconverter_enable_a,
  output logic [3:0] decim_code_a,
  output logic [5:0] decim_div_a,
  output logic dual_band_a,
  // Channel B datapath controls.
  output logic downconverter_enable_b,
  output logic [3:0] decim_code_b,
  output logic [5:0] decim_div_b,
  output logic dual_band_b
);

  // ========================================================================
  // Ratio decoding

  // Maps a ratio code to its divisor; unused codes give zero.
  function automatic logic [5:0] dcsm_div(input logic [3:0] code);
    logic [5:0] d;
    d = `DCSM_DIV_NONE;
    case (code)
      `DCSM_DEC4: d = `DCSM_DIV4;
      `DCSM_DEC6: d = `DCSM_DIV6;
      `DCSM_DEC8: d = `DCSM_DIV8;
      `DCSM_DEC9: d = `DCSM_DIV9;
      `DCSM_DEC10: d = `DCSM_DIV10;
      `DCSM_DEC12: d = `DCSM_DIV12;
      `DCSM_DEC18A: d = `DCSM_DIV18;
      `DCSM_DEC18B: d = `DCSM_DIV18;
      `DCSM_DEC20: d = `DCSM_DIV20;
      `DCSM_DEC32: d = `DCSM_DIV32;
      default: d = `DCSM_DIV_NONE;
    endcase
    return d;
  endfunction : dcsm_div

  // ========================================================================
  // State

  dcsm_state_t st_q;
  dcsm_state_t st_d;
  logic [15:0] idx;
  logic sys_rise;
  logic acc;
  logic wen;

  // Word index of the access and the SYSREF edge seen past the synchroniser.
  assign idx = paddr[17:2];
  assign sys_rise = st_q.sync1 && !st_q.sync2;
  assign acc = psel && penable;

  // Writes land only on the completing edge of an aligned access; a misaligned
  // address would otherwise alias onto the word that holds it.
  assign wen = acc && st_q.pready && pwrite && pstrb[0] && (paddr[1:0] == 2'b00);

  // ========================================================================
  // Next state

  // Synchroniser, reset pulses, register writes and the one-wait APB answer.
  always_comb begin
    logic [15:0] base;
    logic hit;
    logic [31:0] rd;
    base = `DCSM_PAGE_A;
    hit = 1'b0;
    rd = 32'h0000_0000;
    st_d = st_q;
    // Two flip-flops keep a metastable sysref away from the edge detector,
    // which reads only the second and third stages.
    st_d.sync0 = sysref;
    st_d.sync1 = st_q.sync0;
    st_d.sync2 = st_q.sync1;
    st_d.clkdiv_rst = sys_rise && !st_q.mask_clkdiv;
    st_d.osc_rst = sys_rise && !st_q.mask_osc;
    st_d.local_multiframe_counter_rst = sys_rise && !st_q.mask_osc;
    // One wait state: pready rises after the first access edge, so the
    // transfer completes and any write lands on the second one.
    st_d.pready = acc && !st_q.pready;
    st_d.pslverr = 1'b0;
    st_d.prdata = 32'h0000_0000;
    // Global registers; reserved bits are dropped and read as zero.
    if (idx == `DCSM_IDX_SYNC) begin
      hit = 1'b1;
      rd[`DCSM_BIT_CLKDIV] = st_q.mask_clkdiv;
      rd[`DCSM_BIT_OSC] = st_q.mask_osc;
      if (wen) begin
        st_d.mask_clkdiv = pwdata[`DCSM_BIT_CLKDIV];
        st_d.mask_osc = pwdata[`DCSM_BIT_OSC];
      end
    end else if (idx == `DCSM_IDX_STATUS) begin
      hit = 1'b1;
      rd[`DCSM_ST_LEVEL] = st_q.sync2;
      rd[`DCSM_ST_BAD_A] = st_q.ratio_bad[0];
      rd[`DCSM_ST_BAD_B] = st_q.ratio_bad[1];
    end
    // Each channel owns its own copy of the decimation page.
    for (int ch = 0; ch < 2; ch++) begin
      base = (ch == 0) ? `DCSM_PAGE_A : `DCSM_PAGE_B;
      if (idx == base + `DCSM_IDX_EN) begin
        hit = 1'b1;
        rd[`DCSM_BIT_EN] = st_q.downconverter_enable[ch];
        if (wen) begin
          st_d.downconverter_enable[ch] = pwdata[`DCSM_BIT_EN];
        end
      end else if (idx == base + `DCSM_IDX_RATIO) begin
        hit = 1'b1;
        rd[`DCSM_RATIO_MSB:0] = st_q.ratio[ch];
        if (wen) begin
          st_d.ratio[ch] = pwdata[`DCSM_RATIO_MSB:0];
          st_d.div[ch] = dcsm_div(pwdata[`DCSM_RATIO_MSB:0]);
          st_d.ratio_bad[ch] = (dcsm_div(pwdata[`DCSM_RATIO_MSB:0]) == `DCSM_DIV_NONE);
        end
      end else if (idx == base + `DCSM_IDX_BAND) begin
        hit = 1'b1;
        rd[`DCSM_BIT_BAND] = st_q.dual_band[ch];
        if (wen) begin
          st_d.dual_band[ch] = pwdata[`DCSM_BIT_BAND];
        end
      end
    end
    // Misaligned or unmapped words answer with an error and zero data.
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
    if (acc && !st_q.pready) begin
      st_d.pslverr = !hit;
      st_d.prdata = (hit && !pwrite) ? rd : 32'h0000_0000;
    end
  end

  // Registers the whole state; reset clears every field except div, which loads divide 4 on both channels.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.div <= {`DCSM_DIV4, `DCSM_DIV4};
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Outputs, each taken from the state word

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign clkdiv_reset = st_q.clkdiv_rst;
  assign osc_phase_reset = st_q.osc_rst;
  assign local_multiframe_counter_reset = st_q.local_multiframe_counter_rst;
  assign downconverter_enable_a = st_q.downconverter_enable[0];
  assign downconverter_enable_b = st_q.downconverter_enable[1];
  assign decim_code_a = st_q.ratio[0];
  assign decim_code_b = st_q.ratio[1];
  assign decim_div_a = st_q.div[0];
  assign decim_div_b = st_q.div[1];
  assign dual_band_a = st_q.dual_band[0];
  assign dual_band_b = st_q.dual_band[1];

  // ========================================================================
  // Checks

  // Every write check keys on the completing edge of an aligned access with the
  // low byte strobe set; the datapath outputs change one edge later.
  logic wr_done;
  assign wr_done = acc && st_q.pready && pwrite && pstrb[0] && (paddr[1:0] == 2'b00);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // An unmasked rise reaches the divider reset one edge after it is seen.
  clkdiv_fire_a: assert property (
    sys_rise && !st_q.mask_clkdiv ##1 !st_q.mask_clkdiv |-> clkdiv_reset ##1 !clkdiv_reset)
    else $error("divider reset missing after unmasked sysref");

  // A divider reset only ever follows an unmasked rise.
  clkdiv_mask_a: assert property (
    clkdiv_reset |-> $past(sys_rise) && !$past(st_q.mask_clkdiv))
    else $error("divider reset without unmasked sysref");

  // Oscillator and counter resets come together from an unmasked rise.
  osc_fire_a: assert property (
    sys_rise && !st_q.mask_osc |=> osc_phase_reset && local_multiframe_counter_reset)
    else $error("oscillator or counter reset missing");

  // A set oscillator mask keeps both resets low.
  osc_mask_a: assert property (
    osc_phase_reset || local_multiframe_counter_reset |-> !$past(st_q.mask_osc) && osc_phase_reset == local_multiframe_counter_reset)
    else $error("oscillator reset despite mask");

  // A write to the second page leaves the first channel alone.
  page_split_a: assert property (
    wr_done && idx == `DCSM_PAGE_B + `DCSM_IDX_EN |=> downconverter_enable_b == $past(pwdata[0])
      && $stable(downconverter_enable_a))
    else $error("channel pages not independent");

  // The enable bit reaches the datapath one edge after the write.
  enable_write_a: assert property (
    wr_done && idx == `DCSM_PAGE_A + `DCSM_IDX_EN |=> downconverter_enable_a == $past(pwdata[0]))
    else $error("enable bit not applied");

  // Low ratio codes select divide 4, 6 and 8.
  ratio_low_a: assert property (
    (decim_code_a == `DCSM_DEC4 |-> decim_div_a == `DCSM_DIV4)
      and (decim_code_a == `DCSM_DEC6 |-> decim_div_a == `DCSM_DIV6)
      and (decim_code_a == `DCSM_DEC8 |-> decim_div_a == `DCSM_DIV8))
    else $error("low ratio code decoded wrongly");

  // Middle ratio codes select divide 9, 10 and 12.
  ratio_mid_a: assert property (
    (decim_code_b == `DCSM_DEC9 |-> decim_div_b == `DCSM_DIV9)
      and (decim_code_b == `DCSM_DEC10 |-> decim_div_b == `DCSM_DIV10)
      and (decim_code_b == `DCSM_DEC12 |-> decim_div_b == `DCSM_DIV12))
    else $error("middle ratio code decoded wrongly");

  // High ratio codes select divide 20 and 32.
  ratio_high_a: assert property (
    (decim_code_a == `DCSM_DEC20 |-> decim_div_a == `DCSM_DIV20)
      and (decim_code_a == `DCSM_DEC32 |-> decim_div_a == `DCSM_DIV32))
    else $error("high ratio code decoded wrongly");

  // Both doubtful codes decode to divide 18.
  ratio_dup_a: assert property (
    decim_code_a == `DCSM_DEC18A || decim_code_a == `DCSM_DEC18B |-> decim_div_a == `DCSM_DIV18)
    else $error("divide 18 codes decoded wrongly");

  // The band bit follows a write to its own channel page.
  band_write_a: assert property (
    wr_done && idx == `DCSM_PAGE_B + `DCSM_IDX_BAND |=> dual_band_b == $past(pwdata[0])
      && $stable(dual_band_a))
    else $error("band bit not applied");

  // Every access is answered on the second access edge.
  apb_answer_a: assert property (
    acc && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // Middle ratio codes on the first channel select divide 9, 10 and 12.
  first_mid_a: assert property (
    (decim_code_a == `DCSM_DEC9 |-> decim_div_a == `DCSM_DIV9)
      and (decim_code_a == `DCSM_DEC10 |-> decim_div_a == `DCSM_DIV10)
      and (decim_code_a == `DCSM_DEC12 |-> decim_div_a == `DCSM_DIV12))
    else $error("middle ratio code on first channel decoded wrongly");

  // Low ratio codes on the second channel select divide 4, 6 and 8.
  second_low_a: assert property (
    (decim_code_b == `DCSM_DEC4 |-> decim_div_b == `DCSM_DIV4)
      and (decim_code_b == `DCSM_DEC6 |-> decim_div_b == `DCSM_DIV6)
      and (decim_code_b == `DCSM_DEC8 |-> decim_div_b == `DCSM_DIV8))
    else $error("low ratio code on second channel decoded wrongly");

  // High ratio codes on the second channel select divide 20 and 32.
  second_high_a: assert property (
    (decim_code_b == `DCSM_DEC20 |-> decim_div_b == `DCSM_DIV20)
      and (decim_code_b == `DCSM_DEC32 |-> decim_div_b == `DCSM_DIV32))
    else $error("high ratio code on second channel decoded wrongly");

  // Both doubtful codes on the second channel decode to divide 18.
  second_dup_a: assert property (
    decim_code_b == `DCSM_DEC18A || decim_code_b == `DCSM_DEC18B |-> decim_div_b == `DCSM_DIV18)
    else $error("divide 18 codes on second channel decoded wrongly");

  // A ratio write stores its code for the first channel.
  ratio_store_a: assert property (
    wr_done && idx == `DCSM_PAGE_A + `DCSM_IDX_RATIO
      |=> decim_code_a == $past(pwdata[`DCSM_RATIO_MSB:0]))
    else $error("ratio code not stored");

  // The band bit of the first channel follows its own page only.
  band_first_a: assert property (
    wr_done && idx == `DCSM_PAGE_A + `DCSM_IDX_BAND |=> dual_band_a == $past(pwdata[0])
      && $stable(dual_band_b))
    else $error("first channel band bit not applied");

  // Without a completed write the enable, ratio code and band controls hold their values.
  write_idle_a: assert property (
    !wr_done |=> $stable(downconverter_enable_a) && $stable(downconverter_enable_b) && $stable(decim_code_a)
      && $stable(decim_code_b) && $stable(dual_band_a) && $stable(dual_band_b))
    else $error("datapath control changed without a write");

  // A misaligned access is answered with an error and zero data.
  misalign_err_a: assert property (
    acc && !pready && paddr[1:0] != 2'b00 |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("misaligned access not refused");

  // The oscillator reset lasts a single cycle per rise.
  osc_single_a: assert property (
    osc_phase_reset |=> !osc_phase_reset)
    else $error("oscillator reset longer than one cycle");

  // The divider reset lasts a single cycle per rise.
  clkdiv_single_a: assert property (
    clkdiv_reset |=> !clkdiv_reset)
    else $error("divider reset longer than one cycle");

  // Main scenarios.
  sync_both_c: cover property (clkdiv_reset && osc_phase_reset);
  sync_masked_c: cover property (sys_rise && st_q.mask_clkdiv && st_q.mask_osc);
  ratio_write_c: cover property (wr_done && idx == `DCSM_PAGE_B + `DCSM_IDX_RATIO);
  bad_addr_c: cover property (pready && pslverr);
  enable_both_c: cover property (downconverter_enable_a && downconverter_enable_b);

endmodule : dcsm_top

// ==== verif/dcsm_top_tb_top.sv ====
// Self-checking bench for the converter configuration bank.
// Assumes dcsm_top with an 18-bit APB byte address, word index times four.
`timescale 1ns/100ps
module dcsm_top_tb_top;
  // ==========================================================================
  // Design ports and bench counters.
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sysref = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, clkdiv_reset, osc_phase_reset, local_multiframe_counter_reset;
  logic downconverter_enable_a, downconverter_enable_b, dual_band_a, dual_band_b;
  logic [3:0] decim_code_a, decim_code_b;
  logic [5:0] decim_div_a, decim_div_b;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // Divisor expected for every ratio code; unused codes give zero.
  localparam logic [5:0] DIVT [16] = '{6'h04, 6'h06, 6'h08, 6'h09, 6'h0A, 6'h0C, 6'h00,
    6'h12, 6'h12, 6'h14, 6'h00, 6'h00, 6'h20, 6'h00, 6'h00, 6'h00};
  // Ratio codes that the host may program; the others are left alone.
  localparam logic [3:0] CODES [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8,
    4'h9, 4'hC};

  dcsm_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysref(sysref), .clkdiv_reset(clkdiv_reset),
    .osc_phase_reset(osc_phase_reset), .local_multiframe_counter_reset(local_multiframe_counter_reset), .downconverter_enable_a(downconverter_enable_a),
    .decim_code_a(decim_code_a), .decim_div_a(decim_div_a), .dual_band_a(dual_band_a),
    .downconverter_enable_b(downconverter_enable_b), .decim_code_b(decim_code_b), .decim_div_b(decim_div_b),
    .dual_band_b(dual_band_b));

  // ==========================================================================
  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end

  // ==========================================================================
  // Shared tasks: compare, one APB transfer, closing report.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // The request is held until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Scenario: reset values of both decimation pages, the sync register and the channel A divisor and enable outputs.
  task automatic t_reset();
    chk("div_a", {26'h0, decim_div_a}, 32'h4);
    chk("en_a", {31'h0, downconverter_enable_a}, 32'h0);
    foreach (DIVT[i]) begin
      if (i < 3) begin
        apb(1'b0, 18'h14000 + 18'(i * 4), 32'h0);
        chk("reset_a", rd, 32'h0);
        apb(1'b0, 18'h16000 + 18'(i * 4), 32'h0);
        chk("reset_b", rd, 32'h0);
      end
    end
    apb(1'b0, 18'h000F8, 32'h0);
    chk("reset_sync", rd, 32'h0);
    $display("Test reset done");
  endtask : t_reset

  // Scenario: every listed ratio code on both channels, opposite order on each.
  task automatic t_ratio();
    for (int k = 0; k < 10; k++) begin
      apb(1'b1, 18'h14004, {28'h0, CODES[k]});
      apb(1'b1, 18'h16004, {28'h0, CODES[9 - k]});
      @(posedge clk_sys);
      chk("div_a", {26'h0, decim_div_a}, {26'h0, DIVT[CODES[k]]});
      chk("div_b", {26'h0, decim_div_b}, {26'h0, DIVT[CODES[9 - k]]});
      chk("code_a", {28'h0, decim_code_a}, {28'h0, CODES[k]});
      chk("code_b", {28'h0, decim_code_b}, {28'h0, CODES[9 - k]});
      apb(1'b0, 18'h14004, 32'h0);
      chk("ratio_rd_a", rd, {28'h0, CODES[k]});
      apb(1'b0, 18'h16004, 32'h0);
      chk("ratio_rd_b", rd, {28'h0, CODES[9 - k]});
      apb(1'b0, 18'h00100, 32'h0);
      chk("status", rd, 32'h0);
    end
    $display("Test ratio done");
  endtask : t_ratio

  // Scenario: enable and band bits per channel, with no crosstalk.
  task automatic t_mode();
    apb(1'b1, 18'h14000, 32'h1);
    apb(1'b1, 18'h16008, 32'h1);
    @(posedge clk_sys);
    chk("en", {downconverter_enable_a, downconverter_enable_b}, 32'h2);
    chk("band", {dual_band_a, dual_band_b}, 32'h1);
    apb(1'b0, 18'h14000, 32'h0);
    chk("en_rd_a", rd, 32'h1);
    apb(1'b1, 18'h16000, 32'h1);
    apb(1'b1, 18'h14008, 32'h1);
    @(posedge clk_sys);
    chk("en_both", {downconverter_enable_a, downconverter_enable_b}, 32'h3);
    chk("band_both", {dual_band_a, dual_band_b}, 32'h3);
    apb(1'b1, 18'h14000, 32'h0);
    apb(1'b1, 18'h16008, 32'h0);
    @(posedge clk_sys);
    chk("en_off", {downconverter_enable_a, dual_band_b}, 32'h0);
    chk("kept", {downconverter_enable_b, dual_band_a}, 32'h3);
    apb(1'b0, 18'h00200, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    apb(1'b1, 18'h14001, 32'h1);
    chk("misalign_err", {31'h0, er}, 32'h1);
    pstrb <= 4'hE;
    apb(1'b1, 18'h14000, 32'h1);
    pstrb <= 4'hF;
    @(posedge clk_sys);
    chk("no_write", {31'h0, downconverter_enable_a}, 32'h0);
    $display("Test mode done");
  endtask : t_mode

  // Scenario: one SYSREF rise under a mask value; count the reset pulses.
  task automatic t_sync(input logic [31:0] m, input int ec, input int eo);
    int nc;
    int no;
    nc = 0;
    no = 0;
    apb(1'b1, 18'h000F8, m);
    apb(1'b0, 18'h000F8, 32'h0);
    chk("mask_rd", rd, m);
    @(posedge clk_sys);
    sysref <= 1'b1;
    repeat (8) begin
      @(posedge clk_sys);
      nc = nc + 32'(clkdiv_reset === 1'b1);
      no = no + 32'(osc_phase_reset === 1'b1);
      chk("local_multiframe_counter_eq_osc", {31'h0, local_multiframe_counter_reset}, {31'h0, osc_phase_reset});
    end
    sysref <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("clkdiv_pulses", 32'(nc), 32'(ec));
    chk("osc_pulses", 32'(no), 32'(eo));
    $display("Test sync done");
  endtask : t_sync

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_ratio();
    t_mode();
    t_sync(32'h00, 1, 1);
    t_sync(32'h40, 0, 1);
    t_sync(32'h20, 1, 0);
    t_sync(32'h60, 0, 0);
    test_done();
  end
endmodule : dcsm_top_tb_top
